//--- rtl/synth_ctl_pkg.sv
// constants shared by the synthesizer control block and its bench
// assumes a 32-bit axi4-lite master and one 100 MHz clock
package synth_ctl_pkg;
	// ---------------------------------------------------------------
	// register indices; byte address is index times four
	// ---------------------------------------------------------------
	localparam logic [6:0] REG_MAIN = 7'h00;
	localparam logic [6:0] REG_CAL_CLOCK = 7'h01;
	localparam logic [6:0] REG_OUT_MUX = 7'h02;
	localparam logic [6:0] REG_CORE = 7'h03;
	localparam logic [6:0] REG_LOCK_TYPE = 7'h3B;
	localparam logic [6:0] REG_LOCK_DELAY = 7'h3C;
	localparam logic [6:0] REG_STATUS = 7'h6E;
	localparam logic [6:0] REG_DIVIDER = 7'h04;
	localparam logic [6:0] REG_LIMIT = 7'h6F;
	// ---------------------------------------------------------------
	// field positions
	// ---------------------------------------------------------------
	localparam int MAIN_CAL_EN_BIT = 3;
	localparam int MAIN_PIN_SEL_BIT = 2;
	localparam int MAIN_MUTE_BIT = 9;
	localparam int STATUS_LOCK_LO = 9;
	localparam int CORE_FORCE_BIT = 8;
	localparam int BAND_FORCE_BIT = 9;
	localparam int AMP_FORCE_BIT = 10;
	// ---------------------------------------------------------------
	// values and timing
	// ---------------------------------------------------------------
	localparam logic [2:0] CORE_NO_ASSIST = 3'h7;
	localparam logic [2:0] CAL_DIV_MAX = 3'h5;
	localparam logic [4:0] DIV_CODE_LAST = 5'h0C;
	localparam logic [1:0] SEL_VCO = 2'h1;
	localparam logic [1:0] SEL_DIVIDER_CODE = 2'h0;
	localparam logic [1:0] SEL_SYSREF = 2'h2;
	localparam logic [15:0] RESET_DELAY = 16'h0000;
	localparam logic [7:0] CAL_TICKS = 8'h20;
	localparam logic [7:0] AMP_TICKS = 8'h08;
	localparam logic [2:0] LOCK_MULT_SHIFT = 3'h2;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	typedef enum {CAL_IDLE, CAL_BAND, CAL_AMP, CAL_WAIT} cal_state_e;
endpackage

//--- rtl/reg_store_if.sv
// write/read carrier between the control block and its register memory
// assumes one clock shared by both ends
`timescale 1ns/1ps
`default_nettype none
interface reg_store_if;
	logic wrEn;
	logic [6:0] wrIdx;
	logic [31:0] wrData;
	logic [6:0] rdIdx;
	logic [31:0] rdData;
	modport ctrl (output wrEn, output wrIdx, output wrData, output rdIdx, input rdData);
	modport mem (input wrEn, input wrIdx, input wrData, input rdIdx, output rdData);
endinterface
`default_nettype wire

//--- rtl/reg_store.sv
// small word memory for the readback image of software registers
// assumes the writer keeps the live copies; read data come from a flop
`timescale 1ns/1ps
`default_nettype none
module reg_store (
	// clock and reset
	input wire logic ref_clk,
	input wire logic rst,
	// access
	reg_store_if.mem port
);
	logic [31:0] words [0:127];
	logic [31:0] rdq;
	// ---------------------------------------------------------------
	// storage, read registered
	// ---------------------------------------------------------------
	always_ff @(posedge ref_clk) begin
		if (port.wrEn) begin
			words[port.wrIdx] <= port.wrData;
		end
		if (rst) begin
			rdq <= 32'h00000000;
		end else begin
			rdq <= words[port.rdIdx];
		end
	end
	assign port.rdData = rdq;
endmodule
`default_nettype wire

//--- rtl/synth_lock_detect_vco_cal_divider_code.sv
// control side of a wideband synthesizer: lock indicator, pin function,
// calibration sequencing and channel divider decode
// assumes axi4-lite master on ref_clk; reference and lock inputs are async
// Notes on behaviour
// - lock type 0 calibration, 1 tune plus calibration
// - readback mode drives serial data, never tristate
// - lock status readable at status bits 10:9
// - calibration indicator low from band calibration start through delay
// - delay equals four times field, phase cycles
// - calibration indicator holds until calibration write with reference present
// - tune indicator needs calibration, delay, lock
// - tune indicator freezes while reference absent
// - mute output when enabled and tune indicator low
// - main write with enable starts band calibration only while reference present
// - every main write starts amplitude calibration
// - assist levels set core and force bits
// - divider is product of four segments
// - codes 0..12 map ratios, 13..31 invalid
// - divider powered if output selects divider/sysref
// - pin select 0 readback, 1 lock
// - calibration clock reference over power of two
`timescale 1ns/1ps
`default_nettype none
module synth_lock_detect_vco_cal_divider_code (
	// clock and reset
	input wire logic ref_clk,
	input wire logic rst,
	// axi4-lite write address
	input wire logic [31:0] awaddr,
	input wire logic awvalid,
	output logic awready,
	// axi4-lite write data
	input wire logic [31:0] wdata,
	input wire logic [3:0] wstrb,
	input wire logic wvalid,
	output logic wready,
	// axi4-lite write response
	output logic [1:0] bresp,
	output logic bvalid,
	input wire logic bready,
	// axi4-lite read
	input wire logic [31:0] araddr,
	input wire logic arvalid,
	output logic arready,
	output logic [31:0] rdata,
	output logic [1:0] rresp,
	output logic rvalid,
	input wire logic rready,
	// analog-side inputs, asynchronous
	input wire logic referenceValid,
	input wire logic phaseTick,
	input wire logic loopLocked,
	input wire logic serialReadData,
	// pin and analog controls
	output logic multipurposeOutPin,
	output logic multipurposeOutPinOeN,
	output logic outputMute,
	output logic dividerPower,
	output logic [4:0] dividerRatioLog,
	output logic [7:0] dividerRatio,
	output logic [2:0] calCore,
	output logic calBusy
);
	typedef struct packed {
		logic [31:0] mainReg;
		logic [2:0] calDiv;
		logic [1:0] selA;
		logic [1:0] selB;
		logic [2:0] coreSelect;
		logic coreForce;
		logic bandForce;
		logic ampForce;
		logic [4:0] dividerCode;
		logic lockType;
		logic [15:0] lockDelay;
		logic awHeld;
		logic [31:0] awAddr;
		logic wHeld;
		logic [31:0] wData;
		logic [3:0] wStrb;
		logic bPend;
		logic [1:0] bResp;
		logic rPhase;
		logic rPend;
		logic [31:0] rData;
		logic [6:0] rIdx;
		logic [1:0] rResp;
		logic [1:0] refSync;
		logic [1:0] tickSync;
		logic tickLast;
		logic [1:0] lockSync;
		logic [1:0] sdoSync;
		logic [4:0] smDivCnt;
		synth_ctl_pkg::cal_state_e calState;
		logic bandRun;
		logic [7:0] calCnt;
		logic [17:0] delayCnt;
		logic delayRun;
		logic calOnly;
		logic tuneInd;
		logic pinQ;
		logic muteQ;
		logic powerQ;
		logic [4:0] logQ;
		logic [7:0] ratioQ;
	} state_s;

	state_s cur;
	state_s next_cur;
	reg_store_if store ();

	reg_store mem (
		.ref_clk(ref_clk),
		.rst(rst),
		.port(store)
	);

	// ---------------------------------------------------------------
	// helpers
	// ---------------------------------------------------------------
	// segment b: 1 for code 0, else 2 or 3; others fixed per code
	function automatic logic [1:0] stage_b(input logic [4:0] code);
		stage_b = (code == 5'h00) ? 2'h1 : (code[0] ? 2'h2 : 2'h3);
	endfunction
	// log2 of stage c times stage d
	function automatic logic [2:0] stage_cd_log(input logic [4:0] code);
		case (code)
			5'h00, 5'h01, 5'h02: stage_cd_log = 3'h0;
			5'h03, 5'h04: stage_cd_log = 3'h1;
			5'h05, 5'h06: stage_cd_log = 3'h2;
			5'h07, 5'h08: stage_cd_log = 3'h3;
			5'h09, 5'h0A: stage_cd_log = 3'h4;
			default: stage_cd_log = 3'h5;
		endcase
	endfunction
	// full ratio from the four segments, zero for invalid codes
	function automatic logic [7:0] ratio_of(input logic [4:0] code);
		logic [7:0] base;
		base = (stage_b(code) == 2'h3) ? 8'h06 : ((stage_b(code) == 2'h2) ? 8'h04 : 8'h02);
		if (code > synth_ctl_pkg::DIV_CODE_LAST) begin
			ratio_of = 8'h00;
		end else begin
			ratio_of = 8'(base << stage_cd_log(code));
		end
	endfunction
	function automatic logic sel_uses_div(input logic [1:0] sel);
		sel_uses_div = (sel == synth_ctl_pkg::SEL_DIVIDER_CODE) || (sel == synth_ctl_pkg::SEL_SYSREF);
	endfunction

	// ---------------------------------------------------------------
	// next state
	// ---------------------------------------------------------------
	always_comb begin
		logic [6:0] wIdx;
		logic [31:0] wVal;
		logic doWrite;
		logic smTick;
		logic pdEdge;
		logic [31:0] rv;
		wIdx = cur.awAddr[8:2];
		wVal = cur.wData;
		doWrite = 1'b0;
		smTick = 1'b0;
		pdEdge = 1'b0;
		rv = 32'h00000000;
		next_cur = cur;
		store.wrEn = 1'b0;
		store.wrIdx = wIdx;
		store.wrData = wVal;
		// memory address leads by one cycle so its data meet rPhase
		store.rdIdx = (arvalid && !cur.rPhase && !cur.rPend) ? araddr[8:2] : cur.rIdx;

		// synchronisers; only the second stage is read below
		next_cur.refSync = {cur.refSync[0], referenceValid};
		next_cur.tickSync = {cur.tickSync[0], phaseTick};
		next_cur.lockSync = {cur.lockSync[0], loopLocked};
		next_cur.sdoSync = {cur.sdoSync[0], serialReadData};
		next_cur.tickLast = cur.tickSync[1];
		pdEdge = cur.tickSync[1] & ~cur.tickLast;

		// write channel capture, either order
		if (awvalid && !cur.awHeld && !cur.bPend) begin
			next_cur.awHeld = 1'b1;
			next_cur.awAddr = awaddr;
		end
		if (wvalid && !cur.wHeld && !cur.bPend) begin
			next_cur.wHeld = 1'b1;
			next_cur.wData = wdata;
			next_cur.wStrb = wstrb;
		end
		if (cur.awHeld && cur.wHeld && !cur.bPend) begin
			doWrite = 1'b1;
			next_cur.awHeld = 1'b0;
			next_cur.wHeld = 1'b0;
			next_cur.bPend = 1'b1;
			next_cur.bResp = synth_ctl_pkg::RESP_OKAY;
			store.wrEn = (cur.wStrb == 4'hF);
		end
		if (cur.bPend && bready) begin
			next_cur.bPend = 1'b0;
		end

		// register writes; full-word only, partial strobes ignored
		if (doWrite && cur.wStrb == 4'hF) begin
			case (wIdx)
				synth_ctl_pkg::REG_MAIN: begin
					next_cur.mainReg = wVal;
					next_cur.calState = synth_ctl_pkg::CAL_AMP;
					next_cur.bandRun = wVal[synth_ctl_pkg::MAIN_CAL_EN_BIT] & cur.refSync[1];
					next_cur.calCnt = 8'h00;
					if (wVal[synth_ctl_pkg::MAIN_CAL_EN_BIT] && cur.refSync[1]) begin
						next_cur.calState = synth_ctl_pkg::CAL_BAND;
						next_cur.calOnly = 1'b0;
						next_cur.tuneInd = 1'b0;
						next_cur.delayRun = 1'b0;
						next_cur.delayCnt = 18'h00000;
					end
				end
				synth_ctl_pkg::REG_CAL_CLOCK:
					next_cur.calDiv = (wVal[2:0] > synth_ctl_pkg::CAL_DIV_MAX) ? synth_ctl_pkg::CAL_DIV_MAX : wVal[2:0];
				synth_ctl_pkg::REG_OUT_MUX: begin
					next_cur.selA = wVal[1:0];
					next_cur.selB = wVal[3:2];
				end
				synth_ctl_pkg::REG_CORE: begin
					next_cur.coreSelect = wVal[2:0];
					next_cur.coreForce = wVal[synth_ctl_pkg::CORE_FORCE_BIT];
					next_cur.bandForce = wVal[synth_ctl_pkg::BAND_FORCE_BIT];
					next_cur.ampForce = wVal[synth_ctl_pkg::AMP_FORCE_BIT];
				end
				synth_ctl_pkg::REG_DIVIDER: next_cur.dividerCode = wVal[4:0];
				synth_ctl_pkg::REG_LOCK_TYPE: next_cur.lockType = wVal[0];
				synth_ctl_pkg::REG_LOCK_DELAY: next_cur.lockDelay = wVal[15:0];
				default: next_cur.bResp = (wIdx > synth_ctl_pkg::REG_LIMIT) ? synth_ctl_pkg::RESP_SLVERR : synth_ctl_pkg::RESP_OKAY;
			endcase
		end

		// read: accept, wait one cycle for memory, answer
		if (arvalid && !cur.rPhase && !cur.rPend) begin
			next_cur.rPhase = 1'b1;
			next_cur.rIdx = araddr[8:2];
			next_cur.rResp = (araddr[8:2] > synth_ctl_pkg::REG_LIMIT) ? synth_ctl_pkg::RESP_SLVERR : synth_ctl_pkg::RESP_OKAY;
		end
		if (cur.rPhase) begin
			case (cur.rIdx)
				synth_ctl_pkg::REG_STATUS: begin
					rv[synth_ctl_pkg::STATUS_LOCK_LO +: 2] = {cur.tuneInd, cur.calOnly};
					rv[0] = (cur.calState != synth_ctl_pkg::CAL_IDLE);
					rv[1] = cur.delayRun;
				end
				synth_ctl_pkg::REG_CORE: rv = {21'h000000, cur.ampForce, cur.bandForce, cur.coreForce, 5'h00, cur.coreSelect};
				// live copies keep their reset values; memory words start unknown
				synth_ctl_pkg::REG_CAL_CLOCK: rv = {29'h0, cur.calDiv};
				synth_ctl_pkg::REG_OUT_MUX: rv = {28'h0, cur.selB, cur.selA};
				synth_ctl_pkg::REG_DIVIDER: rv = {27'h0, cur.dividerCode};
				synth_ctl_pkg::REG_LOCK_TYPE: rv = {31'h0, cur.lockType};
				synth_ctl_pkg::REG_LOCK_DELAY: rv = {16'h0, cur.lockDelay};
				synth_ctl_pkg::REG_MAIN: rv = store.rdData;
				default: rv = 32'h00000000;
			endcase
			next_cur.rData = rv;
			next_cur.rPhase = 1'b0;
			next_cur.rPend = 1'b1;
		end
		if (cur.rPend && rready) begin
			next_cur.rPend = 1'b0;
		end

		// state machine clock: reference over 2^div, as enable pulse
		next_cur.smDivCnt = cur.smDivCnt + 5'h01;
		smTick = ((cur.smDivCnt & 5'((6'h01 << cur.calDiv) - 6'h01)) == 5'h00) & cur.refSync[1];

		// calibration sequencer; forced settings skip the search
		case (cur.calState)
			synth_ctl_pkg::CAL_IDLE: ;
			synth_ctl_pkg::CAL_BAND:
				if (smTick) begin
					next_cur.calCnt = cur.calCnt + 8'h01;
					if (cur.coreForce && cur.bandForce || cur.calCnt == synth_ctl_pkg::CAL_TICKS) begin
						next_cur.calState = synth_ctl_pkg::CAL_AMP;
						next_cur.calCnt = 8'h00;
					end
				end
			synth_ctl_pkg::CAL_AMP:
				if (smTick) begin
					next_cur.calCnt = cur.calCnt + 8'h01;
					if (cur.ampForce || cur.calCnt == synth_ctl_pkg::AMP_TICKS) begin
						next_cur.calState = synth_ctl_pkg::CAL_IDLE;
						if (cur.bandRun) begin
							next_cur.delayRun = 1'b1;
							next_cur.delayCnt = {cur.lockDelay, 2'b00};
							next_cur.bandRun = 1'b0;
						end
					end
				end
			default: next_cur.calState = synth_ctl_pkg::CAL_IDLE;
		endcase

		// lock delay timer in phase detector cycles
		if (cur.delayRun && cur.calState == synth_ctl_pkg::CAL_IDLE) begin
			if (cur.delayCnt == 18'h00000) begin
				next_cur.delayRun = 1'b0;
				next_cur.calOnly = 1'b1;
			end else if (pdEdge) begin
				next_cur.delayCnt = cur.delayCnt - 18'h00001;
			end
		end

		// tune indicator freezes without reference
		if (cur.refSync[1]) begin
			next_cur.tuneInd = cur.calOnly & cur.lockSync[1] & ~cur.delayRun;
		end

		// pin: readback data or chosen indicator, always driven
		if (cur.mainReg[synth_ctl_pkg::MAIN_PIN_SEL_BIT]) begin
			next_cur.pinQ = cur.lockType ? cur.tuneInd : cur.calOnly;
		end else begin
			next_cur.pinQ = cur.sdoSync[1];
		end
		next_cur.muteQ = cur.mainReg[synth_ctl_pkg::MAIN_MUTE_BIT] & ~cur.tuneInd;
		next_cur.powerQ = sel_uses_div(cur.selA) | sel_uses_div(cur.selB);
		next_cur.ratioQ = ratio_of(cur.dividerCode);
		next_cur.logQ = 5'(stage_cd_log(cur.dividerCode)) + 5'h01;
	end

	// ---------------------------------------------------------------
	// state register
	// ---------------------------------------------------------------
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			cur <= '0;
			cur.coreSelect <= synth_ctl_pkg::CORE_NO_ASSIST;
			cur.lockDelay <= synth_ctl_pkg::RESET_DELAY;
			cur.calState <= synth_ctl_pkg::CAL_IDLE;
			cur.selA <= synth_ctl_pkg::SEL_VCO;
			cur.selB <= synth_ctl_pkg::SEL_VCO;
		end else begin
			cur <= next_cur;
		end
	end

	// outputs from state flops, ready flags gated by two flops, pin enable tied low
	assign awready = ~cur.awHeld & ~cur.bPend;
	assign wready = ~cur.wHeld & ~cur.bPend;
	assign bvalid = cur.bPend;
	assign bresp = cur.bResp;
	assign arready = ~cur.rPhase & ~cur.rPend;
	assign rvalid = cur.rPend;
	assign rdata = cur.rData;
	assign rresp = cur.rResp;
	assign multipurposeOutPin = cur.pinQ;
	assign multipurposeOutPinOeN = 1'b0;
	assign outputMute = cur.muteQ;
	assign dividerPower = cur.powerQ;
	assign dividerRatio = cur.ratioQ;
	assign dividerRatioLog = cur.logQ;
	assign calCore = cur.coreSelect;
	assign calBusy = cur.bandRun;
endmodule
`default_nettype wire

//--- bench/analog_side_model.sv
// stand-in for the analog side: reference, phase ticks, lock, serial bit
// assumes the bench switches reference and lock through refOn and lockOn
`timescale 1ns/1ps
`default_nettype none
module analog_side_model (
	// control from the bench
	input wire logic ref_clk,
	input wire logic refOn,
	input wire logic lockOn,
	// towards the block
	output logic referenceValid,
	output logic phaseTick,
	output logic loopLocked,
	output logic serialReadData
);
	logic [2:0] div = 3'h0;
	logic [7:0] lfsr = 8'hA5;
	// phase clock stops with the reference, as a real divider would
	always @(posedge ref_clk) begin
		div <= refOn ? div + 3'h1 : div;
		lfsr <= {lfsr[6:0], lfsr[7] ^ lfsr[5] ^ lfsr[4] ^ lfsr[3]};
	end
	// reference stays up until the bench drops it on purpose
	assign referenceValid = refOn;
	assign phaseTick = div[2];
	// no lock without reference
	assign loopLocked = lockOn & refOn;
	assign serialReadData = lfsr[0];
endmodule
`default_nettype wire

//--- bench/synth_ctl_asserts.sv
// checker for the synthesizer control block, bound to its top ports
// assumes one clock and a synchronous active-high reset
`timescale 1ns/1ps
`default_nettype none
module synth_ctl_asserts (
	// clock and reset
	input wire logic ref_clk,
	input wire logic rst,
	// bus
	input wire logic [31:0] awaddr,
	input wire logic awvalid,
	input wire logic awready,
	input wire logic [31:0] wdata,
	input wire logic [3:0] wstrb,
	input wire logic wvalid,
	input wire logic wready,
	input wire logic [1:0] bresp,
	input wire logic bvalid,
	input wire logic bready,
	input wire logic arvalid,
	input wire logic arready,
	input wire logic [31:0] rdata,
	input wire logic rvalid,
	input wire logic rready,
	// analog side and outputs
	input wire logic referenceValid,
	input wire logic multipurposeOutPinOeN,
	input wire logic [7:0] dividerRatio,
	input wire logic calBusy
);
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (rst);
	// ---------------------------------------------------------------
	// bus handshakes
	// ---------------------------------------------------------------
	sequence s_wr_take;
		awvalid && awready && wvalid && wready;
	endsequence
	sequence s_rd_take;
		arvalid && arready;
	endsequence
	property p_wr_resp;
		s_wr_take |-> ##[1:3] bvalid;
	endproperty
	a_wr_resp: assert property (p_wr_resp) else $error("write answer late");
	property p_b_hold;
		bvalid && !bready |=> bvalid && $stable(bresp);
	endproperty
	a_b_hold: assert property (p_b_hold) else $error("write answer dropped");
	property p_r_hold;
		rvalid && !rready |=> rvalid && $stable(rdata);
	endproperty
	a_r_hold: assert property (p_r_hold) else $error("read answer dropped");
	property p_rd_lat;
		s_rd_take |-> ##2 rvalid;
	endproperty
	a_rd_lat: assert property (p_rd_lat) else $error("read answer not in two cycles");
	// no new write taken while an answer waits
	property p_no_take;
		bvalid |-> !awready && !wready;
	endproperty
	a_no_take: assert property (p_no_take) else $error("write taken while busy");
	property p_slverr;
		s_wr_take ##0 (awaddr[31:2] > 30'h6F) |-> ##[1:3] (bvalid && bresp == 2'h2);
	endproperty
	a_slverr: assert property (p_slverr) else $error("unmapped write not refused");
	// ---------------------------------------------------------------
	// block behaviour
	// ---------------------------------------------------------------
	property p_pin_driven;
		multipurposeOutPinOeN == 1'b0;
	endproperty
	a_pin_driven: assert property (p_pin_driven) else $error("pin released");
	property p_ratio_legal;
		dividerRatio inside {8'h00, 8'h02, 8'h04, 8'h06, 8'h08, 8'h0C, 8'h10,
			8'h18, 8'h20, 8'h30, 8'h40, 8'h60, 8'h80, 8'hC0};
	endproperty
	a_ratio_legal: assert property (p_ratio_legal) else $error("bad ratio");
	property p_cal_start;
		s_wr_take ##0 (awaddr == 32'h0 && wdata[3] && wstrb == 4'hF && referenceValid)
			|-> ##[1:8] calBusy;
	endproperty
	a_cal_start: assert property (p_cal_start) else $error("no calibration");
endmodule
bind synth_lock_detect_vco_cal_divider_code synth_ctl_asserts chk_u (.ref_clk, .rst, .awaddr,
	.awvalid, .awready, .wdata, .wstrb, .wvalid, .wready, .bresp, .bvalid, .bready,
	.arvalid, .arready, .rdata, .rvalid, .rready, .referenceValid,
	.multipurposeOutPinOeN, .dividerRatio, .calBusy);
`default_nettype wire

//--- bench/synth_lock_detect_vco_cal_divider_code_test.sv
// bench for the synthesizer control block: bus tasks and directed tests
// assumes the analog stand-in and the checker are compiled before it
`timescale 1ns/1ps
`default_nettype none
module synth_lock_detect_vco_cal_divider_code_test;
	logic ref_clk, rst, refOn, lockOn, awvalid, awready, wvalid, wready, bvalid, bready;
	logic arvalid, arready, rvalid, rready, pin, pinOeN, outputMute, dividerPower, calBusy;
	logic referenceValid, phaseTick, loopLocked, serialReadData;
	logic [31:0] awaddr, wdata, araddr, rdata, rd;
	logic [3:0] wstrb;
	logic [1:0] bresp, rresp, resp;
	logic [4:0] ratioLog;
	logic [7:0] dividerRatio;
	logic [2:0] calCore, sdHist;
	logic [7:0] ratioTab [13] = '{8'h02, 8'h04, 8'h06, 8'h08, 8'h0C, 8'h10, 8'h18, 8'h20,
		8'h30, 8'h40, 8'h60, 8'h80, 8'hC0};
	// last entry parks both outputs on the direct path
	logic [3:0] selTab [5] = '{4'h4, 4'h1, 4'h9, 4'h6, 4'h5};
	// log2 of stage c times stage d, plus one, per valid code
	logic [4:0] logTab [13] = '{5'h01, 5'h01, 5'h01, 5'h02, 5'h02, 5'h03, 5'h03, 5'h04,
		5'h04, 5'h05, 5'h05, 5'h06, 5'h06};
	int miscompares = 0, checksDone = 0, n;
	synth_lock_detect_vco_cal_divider_code dut_u (.ref_clk(ref_clk), .rst(rst), .awaddr(awaddr),
		.awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid),
		.wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr),
		.arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid),
		.rready(rready), .referenceValid(referenceValid), .phaseTick(phaseTick),
		.loopLocked(loopLocked), .serialReadData(serialReadData), .multipurposeOutPin(pin),
		.multipurposeOutPinOeN(pinOeN), .outputMute(outputMute), .dividerPower(dividerPower),
		.dividerRatioLog(ratioLog), .dividerRatio(dividerRatio), .calCore(calCore),
		.calBusy(calBusy));
	analog_side_model analog_u (.ref_clk(ref_clk), .refOn(refOn), .lockOn(lockOn),
		.referenceValid(referenceValid), .phaseTick(phaseTick), .loopLocked(loopLocked),
		.serialReadData(serialReadData));
	// serial bit history for the readback path
	always @(posedge ref_clk) begin
		sdHist <= {sdHist[1:0], serialReadData};
	end
	// free-running 100 MHz clock
	initial begin
		ref_clk = 1'b0;
		forever #5 ref_clk = ~ref_clk;
	end
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		checksDone++;
		if (seen !== exp) begin
			miscompares++;
			$display("BAD t=%0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic cyc(input int k);
		repeat (k) @(posedge ref_clk);
	endtask
	// write and read keep bready/rready high, so only valids move
	task automatic wr(input logic [6:0] idx, input logic [31:0] d);
		awaddr <= {23'h0, idx, 2'h0};
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		do begin
			@(posedge ref_clk);
			if (awready && awvalid) awvalid <= 1'b0;
			if (wready && wvalid) wvalid <= 1'b0;
		end while (bvalid !== 1'b1);
		resp = bresp;
	endtask
	task automatic rdr(input logic [6:0] idx);
		araddr <= {23'h0, idx, 2'h0};
		arvalid <= 1'b1;
		do begin
			@(posedge ref_clk);
			if (arready && arvalid) arvalid <= 1'b0;
		end while (rvalid !== 1'b1);
		rd = rdata;
	endtask
	task automatic waitPin(input logic v, input int lim);
		n = 0;
		while (pin !== v && n < lim) begin
			@(posedge ref_clk);
			n++;
		end
	endtask
	task automatic tallyAndFinish();
		$display("checks %0d mismatches %0d", checksDone, miscompares);
		if (miscompares == 0 && checksDone > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask
	// watchdog well past the expected run
	initial begin
		#600000;
		miscompares++;
		tallyAndFinish();
	end
	initial begin
		{rst, refOn, lockOn, bready, rready} <= 5'h1B;
		{awvalid, wvalid, arvalid} <= 3'h0;
		{awaddr, wdata, araddr, wstrb} <= {96'h0, 4'hF};
		repeat (20) @(posedge ref_clk);
		rst <= 1'b0;
		@(posedge ref_clk);
		rdr(synth_ctl_pkg::REG_LOCK_DELAY);
		check(rd, {16'h0, synth_ctl_pkg::RESET_DELAY});
		check(calCore, synth_ctl_pkg::CORE_NO_ASSIST);
		wr(7'h70, 32'h1);
		check(resp, synth_ctl_pkg::RESP_SLVERR);
		$display("registers done");
		for (int c = 0; c < 32; c++) begin
			wr(synth_ctl_pkg::REG_DIVIDER, 32'(c));
			cyc(3);
			check(dividerRatio, c < 13 ? ratioTab[c] : 8'h00);
			if (c < 13) begin
				check(ratioLog, logTab[c]);
			end
		end
		foreach (selTab[i]) begin
			wr(synth_ctl_pkg::REG_OUT_MUX, {28'h0, selTab[i]});
			cyc(3);
			check(dividerPower, selTab[i] != 4'h5);
		end
		$display("divider done");
		// calibration-only indicator, delay field two: eight phase periods
		wr(synth_ctl_pkg::REG_LOCK_TYPE, 32'h0);
		wr(synth_ctl_pkg::REG_LOCK_DELAY, 32'h2);
		wr(synth_ctl_pkg::REG_MAIN, 32'h0000000C);
		cyc(2);
		check(calBusy, 1'b1);
		check(pin, 1'b0);
		n = 0;
		while (calBusy === 1'b1 && n < 5000) begin
			@(posedge ref_clk);
			n++;
		end
		check(pin, 1'b0);
		waitPin(1'b1, 2000);
		check(n >= 56, 1'b1);
		check(n <= 72, 1'b1);
		check(pin, 1'b1);
		rdr(synth_ctl_pkg::REG_STATUS);
		check(rd[9], 1'b1);
		// losing reference must not lower it, nor a write without reference
		refOn <= 1'b0;
		cyc(20);
		check(pin, 1'b1);
		wr(synth_ctl_pkg::REG_MAIN, 32'h0000000C);
		cyc(40);
		check(pin, 1'b1);
		$display("calibration indicator done");
		// tune-plus-calibration indicator with automatic mute
		refOn <= 1'b1;
		wr(synth_ctl_pkg::REG_LOCK_TYPE, 32'h1);
		wr(synth_ctl_pkg::REG_LOCK_DELAY, 32'h0);
		wr(synth_ctl_pkg::REG_MAIN, 32'h0000020C);
		waitPin(1'b1, 400);
		check(pin, 1'b0);
		check(outputMute, 1'b1);
		lockOn <= 1'b1;
		waitPin(1'b1, 400);
		cyc(2);
		check(pin, 1'b1);
		check(outputMute, 1'b0);
		rdr(synth_ctl_pkg::REG_STATUS);
		check(rd[10], 1'b1);
		// reference lost: tune indicator freezes, then follows the loop again
		refOn <= 1'b0;
		cyc(20);
		check(pin, 1'b1);
		{refOn, lockOn} <= 2'h2;
		cyc(10);
		check(pin, 1'b0);
		check(outputMute, 1'b1);
		$display("tune indicator done");
		// readback routing: pin follows the serial bit
		wr(synth_ctl_pkg::REG_MAIN, 32'h0);
		cyc(4);
		repeat (12) begin
			@(posedge ref_clk);
			#1;
			check(pin, sdHist[2]);
			check(pinOeN, 1'b0);
		end
		$display("readback done");
		// full assist skips the search; partial assist loads a starting core
		wr(synth_ctl_pkg::REG_CORE, 32'h00000707);
		wr(synth_ctl_pkg::REG_MAIN, 32'h00000008);
		cyc(4);
		check(calBusy, 1'b0);
		rdr(synth_ctl_pkg::REG_MAIN);
		check(rd, 32'h00000008);
		wr(synth_ctl_pkg::REG_CORE, 32'h00000001);
		check(calCore, 3'h1);
		// slowest state machine clock: a full search takes over a thousand cycles
		wr(synth_ctl_pkg::REG_CAL_CLOCK, 32'h00000007);
		wr(synth_ctl_pkg::REG_MAIN, 32'h00000008);
		cyc(300);
		check(calBusy, 1'b1);
		n = 0;
		while (calBusy === 1'b1 && n < 3000) begin
			@(posedge ref_clk);
			n++;
		end
		check(calBusy, 1'b0);
		check(n >= 900, 1'b1);
		$display("assist done");
		tallyAndFinish();
	end
endmodule
`default_nettype wire
